// *** wake_defines.vh ***
// constants for the wake-up timer control block
`ifndef WAKE_DEFINES_VH
`define WAKE_DEFINES_VH

// register offsets
`define WAKE_ADDR_RELOAD_UPPER 10'h30E
`define WAKE_ADDR_RELOAD_LOWER 10'h30F
`define WAKE_ADDR_FLAG_CTRL 10'h310
`define WAKE_ADDR_STATUS 10'h311
`define WAKE_ADDR_SHUTDOWN 10'h322

// flag-control fields
`define FLAG_CLEAR_BIT 0
`define RC_CAL_ENABLE_BIT 1

// status fields
`define ST_TIMEOUT_LIVE 0
`define ST_TIMEOUT_LATCHED 1
`define ST_COLD_START 2
`define ST_CRYSTAL_LEVEL 3
`define ST_CRYSTAL_SETTLED 4
`define ST_RC_CAL_DONE 5
`define ST_RC_CAL_ERROR 6

// shutdown field
`define SHUTDOWN_REQ_BIT 0

// reset values
`define RELOAD_RESET 16'h0000
`define BYTE_RESET 8'h00

// timing: reference clock and slow oscillator
`define REF_CLK_HZ 100000000
`define SLOW_OSC_HZ 32768
`define CAL_RC_PERIODS 6'h20
`define CAL_TOL_PERCENT 2
`define CAL_NOMINAL_CYCLES ((`REF_CLK_HZ / `SLOW_OSC_HZ) * `CAL_RC_PERIODS)
// window bounds are the nominal count less and plus the tolerance, sized to the counter
`define CAL_LO_CYCLES 20'h175BF
`define CAL_HI_CYCLES 20'h18500
`define CRYSTAL_SETTLE_EDGES 12'h400

// prescaler selections and their divide ratios minus one
`define PRESC_DIV1 16'h0000
`define PRESC_DIV4 16'h0003
`define PRESC_DIV8 16'h0007
`define PRESC_DIV16 16'h000F
`define PRESC_DIV128 16'h007F
`define PRESC_DIV1024 16'h03FF
`define PRESC_DIV8192 16'h1FFF
`define PRESC_DIV65536 16'hFFFF

`endif

// *** wake_prescaler.v ***
// divides the 32.768 kHz tick into the selected wake-up timer tick
`include "wake_defines.vh"

module wake_prescaler (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire slow_tick_in,
  input wire [2:0] presc_sel_in,
  output reg presc_tick_out
);

  reg [15:0] div_count_reg;

  // terminal count for each prescaler setting
  function [15:0] div_limit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: div_limit = `PRESC_DIV1;
        3'h1: div_limit = `PRESC_DIV4;
        3'h2: div_limit = `PRESC_DIV8;
        3'h3: div_limit = `PRESC_DIV16;
        3'h4: div_limit = `PRESC_DIV128;
        3'h5: div_limit = `PRESC_DIV1024;
        3'h6: div_limit = `PRESC_DIV8192;
        default: div_limit = `PRESC_DIV65536;
      endcase
    end
  endfunction

  // count slow ticks; the >= test recovers if the ratio shrinks mid-count
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_count_reg <= 16'h0000;
      presc_tick_out <= 1'b0;
    end else begin
      presc_tick_out <= 1'b0;
      if (slow_tick_in) begin
        if (div_count_reg >= div_limit(presc_sel_in)) begin
          div_count_reg <= 16'h0000;
          presc_tick_out <= 1'b1;
        end else begin
          div_count_reg <= div_count_reg + 16'h0001;
        end
      end
    end
  end

endmodule // wake_prescaler

// *** wake_countdown.v ***
// 16-bit down counter with reload for the wake-up timer
`include "wake_defines.vh"

module wake_countdown (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire tick_in,
  input wire load_in,
  input wire [15:0] reload_in,
  output reg [15:0] count_out,
  output reg timeout_out
);

  // load wins over a tick arriving in the same cycle
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_out <= `RELOAD_RESET;
      timeout_out <= 1'b0;
    end else begin
      timeout_out <= 1'b0;
      if (load_in) begin
        count_out <= reload_in;
      end else if (tick_in) begin
        if (count_out == 16'h0000) begin
          count_out <= reload_in; // [R18]
        end else begin
          count_out <= count_out - 16'h0001; // [R05]
          if (count_out == 16'h0001) begin
            timeout_out <= 1'b1;
          end
        end
      end
    end
  end

endmodule // wake_countdown

// *** wake_unit_top.v ***
// wake-up timer control registers, timer, calibration and shutdown request
//
// Function
// R01: reload value is 16 bits, upper byte and lower byte in two write-only registers
// R02: upper byte write is held pending until the lower byte is written
// R03: host writes the upper byte before the lower byte, never lower alone
// R04: enabled unit with timer counted down to zero triggers a wake-up event
// R05: counter decrements once per prescaler tick, not per oscillator cycle
// R06: flag-control bit 0 written 1 clears timeout and cold-start flags
// R07: flag-control bit 1 enables rc oscillator calibration, resets to 0
// R08: status bit 6 reads 1 when calibration ended with an error
// R09: status bit 5 reads 1 once calibration has finished
// R10: status bit 4 reads 1 when the crystal oscillator has settled
// R11: status bit 3 is the live crystal oscillator level
// R12: status bit 2 is the sticky cold-start flag until cleared
// R13: status bit 1 latches a timer timeout until cleared
// R14: status bit 0 shows counter at zero, bit 7 reads 0
// R15: shutdown bit 0 requests shutdown, which begins only with chip select high
// R16: timeout wakes the chip only while the arm bit is set
// R17: clock-select 1 picks rc oscillator, 0 picks the crystal oscillator
// R18: at zero the counter reloads the committed value and keeps counting
`include "wake_defines.vh"

module wake_unit_top #(
  parameter [19:0] CAL_LO_CYCLES = `CAL_LO_CYCLES,
  parameter [19:0] CAL_HI_CYCLES = `CAL_HI_CYCLES
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [9:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire cs_high_in,
  input wire wake_arm_in,
  input wire timer_clock_select_in,
  input wire crystal_enable_in,
  input wire [2:0] presc_sel_in,
  input wire rc_osc_in,
  input wire crystal_osc_in,
  output reg wake_event_out,
  output reg shutdown_out,
  output reg rc_cal_enable_out
);

  localparam [1:0] CAL_IDLE = 2'h0;
  localparam [1:0] CAL_ALIGN = 2'h1;
  localparam [1:0] CAL_RUN = 2'h2;
  localparam [1:0] CAL_END = 2'h3;

  reg [7:0] reload_upper_reg;
  reg [7:0] reload_lower_reg;
  reg [15:0] reload_count_reg;
  reg reload_load_reg;
  reg flag_clear_reg;
  reg rc_cal_enable_reg;
  reg shutdown_request_bit_reg;
  reg cold_start_flag_reg;
  reg cold_start_seen_reg;
  reg timeout_latched_reg;
  reg rc_prev_reg;
  reg crystal_prev_reg;
  reg slow_prev_reg;
  reg [11:0] settle_count_reg;
  reg crystal_settled_reg;
  reg [1:0] cal_state_reg;
  reg [1:0] cal_state_next;
  reg [19:0] cal_cycles_reg;
  reg [5:0] cal_periods_reg;
  reg rc_cal_done_reg;
  reg rc_cal_error_reg;

  wire wr_upper;
  wire wr_lower;
  wire wr_flag;
  wire wr_shutdown;
  wire flag_clear_pulse;
  wire slow_level;
  wire slow_tick;
  wire rc_rise;
  wire crystal_rise;
  wire presc_tick;
  wire [15:0] timer_count;
  wire timer_timeout;
  wire timeout_live;
  wire [7:0] status_word;

  // one address decode shared by all write strobes
  function addr_hit;
    input [9:0] addr;
    input [9:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // write strobes per register
  assign wr_upper = reg_wr_in && addr_hit(reg_addr_in, `WAKE_ADDR_RELOAD_UPPER);
  assign wr_lower = reg_wr_in && addr_hit(reg_addr_in, `WAKE_ADDR_RELOAD_LOWER);
  assign wr_flag = reg_wr_in && addr_hit(reg_addr_in, `WAKE_ADDR_FLAG_CTRL);
  assign wr_shutdown = reg_wr_in && addr_hit(reg_addr_in, `WAKE_ADDR_SHUTDOWN);

  // a clear acts only at the write, so the bit never blocks later events
  assign flag_clear_pulse = wr_flag && reg_wdata_in[`FLAG_CLEAR_BIT]; // [R06]

  // reload bytes; the upper byte only sits pending in its register
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_upper_reg <= `BYTE_RESET;
      reload_lower_reg <= `BYTE_RESET;
    end else begin
      if (wr_upper) begin
        reload_upper_reg <= reg_wdata_in; // [R01] [R02]
      end
      if (wr_lower) begin
        reload_lower_reg <= reg_wdata_in; // [R01]
      end
    end
  end

  // the lower byte write commits both halves and restarts the counter;
  // a lone lower write reuses the old pending upper byte, hence the order
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reload_count_reg <= `RELOAD_RESET;
      reload_load_reg <= 1'b0;
    end else begin
      reload_load_reg <= wr_lower;
      if (wr_lower) begin
        reload_count_reg <= {reload_upper_reg, reg_wdata_in}; // [R02] [R03]
      end
    end
  end

  // flag-control and shutdown registers
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_clear_reg <= 1'b0;
      rc_cal_enable_reg <= 1'b0;
      shutdown_request_bit_reg <= 1'b0;
    end else begin
      if (wr_flag) begin
        flag_clear_reg <= reg_wdata_in[`FLAG_CLEAR_BIT];
        rc_cal_enable_reg <= reg_wdata_in[`RC_CAL_ENABLE_BIT]; // [R07]
      end
      if (wr_shutdown) begin
        shutdown_request_bit_reg <= reg_wdata_in[`SHUTDOWN_REQ_BIT]; // [R15]
      end
    end
  end

  // edge detect on the slow oscillators; both inputs are already synchronous
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rc_prev_reg <= 1'b0;
      crystal_prev_reg <= 1'b0;
      slow_prev_reg <= 1'b0;
    end else begin
      rc_prev_reg <= rc_osc_in;
      crystal_prev_reg <= crystal_osc_in;
      slow_prev_reg <= slow_level;
    end
  end

  assign rc_rise = rc_osc_in && !rc_prev_reg;
  assign crystal_rise = crystal_osc_in && !crystal_prev_reg;

  // timer clock source selection
  assign slow_level = timer_clock_select_in ? rc_osc_in : crystal_osc_in; // [R17]
  assign slow_tick = slow_level && !slow_prev_reg;

  // prescaler turns the 32 kHz edges into timer ticks
  wake_prescaler prescaler_inst (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .slow_tick_in(slow_tick),
    .presc_sel_in(presc_sel_in),
    .presc_tick_out(presc_tick)
  );

  // the down counter itself
  wake_countdown countdown_inst (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .tick_in(presc_tick), // [R05]
    .load_in(reload_load_reg),
    .reload_in(reload_count_reg),
    .count_out(timer_count),
    .timeout_out(timer_timeout)
  );

  // unlatched zero indication
  assign timeout_live = (timer_count == 16'h0000); // [R14]

  // latched timeout; a timeout in the clearing cycle survives
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timeout_latched_reg <= 1'b0;
    end else if (timer_timeout) begin
      timeout_latched_reg <= 1'b1; // [R13]
    end else if (flag_clear_pulse) begin
      timeout_latched_reg <= 1'b0; // [R06]
    end
  end

  // cold start is caught on the first clock after reset release
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cold_start_seen_reg <= 1'b0;
      cold_start_flag_reg <= 1'b0;
    end else begin
      cold_start_seen_reg <= 1'b1;
      if (!cold_start_seen_reg) begin
        cold_start_flag_reg <= 1'b1; // [R12]
      end else if (flag_clear_pulse) begin
        cold_start_flag_reg <= 1'b0; // [R06]
      end
    end
  end

  // wake-up pulse only while armed
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_event_out <= 1'b0;
    end else begin
      wake_event_out <= timer_timeout && wake_arm_in; // [R04] [R16]
    end
  end

  // crystal settling: count edges while enabled, forget when disabled
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      settle_count_reg <= 12'h000;
      crystal_settled_reg <= 1'b0;
    end else if (!crystal_enable_in) begin
      settle_count_reg <= 12'h000;
      crystal_settled_reg <= 1'b0;
    end else if (crystal_rise && !crystal_settled_reg) begin
      if (settle_count_reg == `CRYSTAL_SETTLE_EDGES - 12'h001) begin
        crystal_settled_reg <= 1'b1; // [R10]
      end
      settle_count_reg <= settle_count_reg + 12'h001;
    end
  end

  // calibration sequencer: measure ref cycles over a fixed number of rc periods
  always @* begin
    cal_state_next = cal_state_reg;
    case (cal_state_reg)
      CAL_IDLE: begin
        if (rc_cal_enable_reg) begin
          cal_state_next = CAL_ALIGN;
        end
      end
      CAL_ALIGN: begin
        if (rc_rise) begin
          cal_state_next = CAL_RUN;
        end else if (cal_cycles_reg > CAL_HI_CYCLES) begin
          cal_state_next = CAL_END; // a dead oscillator never aligns
        end
      end
      CAL_RUN: begin
        // a stalled oscillator ends the run at the high limit
        if ((rc_rise && cal_periods_reg == `CAL_RC_PERIODS - 6'h01) ||
            cal_cycles_reg > CAL_HI_CYCLES) begin
          cal_state_next = CAL_END;
        end
      end
      CAL_END: begin
        cal_state_next = CAL_END;
      end
      default: begin
        cal_state_next = CAL_IDLE;
      end
    endcase
    if (!rc_cal_enable_reg) begin
      cal_state_next = CAL_IDLE;
    end
  end

  // calibration counters and result flags
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_state_reg <= CAL_IDLE;
      cal_cycles_reg <= 20'h00000;
      cal_periods_reg <= 6'h00;
      rc_cal_done_reg <= 1'b0;
      rc_cal_error_reg <= 1'b0;
    end else begin
      cal_state_reg <= cal_state_next;
      case (cal_state_reg)
        CAL_ALIGN: begin
          // the wait is timed too, so a stopped oscillator cannot hang here
          cal_cycles_reg <= rc_rise ? 20'h00000 : cal_cycles_reg + 20'h00001;
          if (cal_state_next == CAL_END) begin
            rc_cal_done_reg <= 1'b1; // [R09]
            rc_cal_error_reg <= 1'b1; // [R08]
          end
        end
        CAL_RUN: begin
          cal_cycles_reg <= cal_cycles_reg + 20'h00001;
          if (rc_rise) begin
            cal_periods_reg <= cal_periods_reg + 6'h01;
          end
          if (cal_state_next == CAL_END) begin
            rc_cal_done_reg <= 1'b1; // [R09]
            rc_cal_error_reg <= (cal_cycles_reg < CAL_LO_CYCLES) ||
                                (cal_cycles_reg > CAL_HI_CYCLES); // [R08]
          end
        end
        CAL_END: begin
          cal_cycles_reg <= cal_cycles_reg;
        end
        default: begin
          cal_cycles_reg <= 20'h00000;
          cal_periods_reg <= 6'h00;
          rc_cal_done_reg <= 1'b0;
          rc_cal_error_reg <= 1'b0;
        end
      endcase
      if (!rc_cal_enable_reg) begin
        rc_cal_done_reg <= 1'b0; // [R09]
        rc_cal_error_reg <= 1'b0; // [R08]
      end
    end
  end

  // status word, reserved bit 7 held low
  assign status_word = {1'b0, // [R14]
                        rc_cal_error_reg, // [R08]
                        rc_cal_done_reg, // [R09]
                        crystal_settled_reg, // [R10]
                        crystal_osc_in, // [R11]
                        cold_start_flag_reg, // [R12]
                        timeout_latched_reg, // [R13]
                        timeout_live}; // [R14]

  // read data: write-only and unmapped addresses return zero
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `WAKE_ADDR_FLAG_CTRL: reg_rdata_out <= {6'h00, rc_cal_enable_reg, flag_clear_reg};
        `WAKE_ADDR_STATUS: reg_rdata_out <= status_word;
        `WAKE_ADDR_SHUTDOWN: reg_rdata_out <= {7'h00, shutdown_request_bit_reg};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // shutdown needs the host to have released chip select
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shutdown_out <= 1'b0;
      rc_cal_enable_out <= 1'b0;
    end else begin
      shutdown_out <= shutdown_request_bit_reg && cs_high_in; // [R15]
      rc_cal_enable_out <= rc_cal_enable_reg; // [R07]
    end
  end

endmodule // wake_unit_top

// *** wake_unit_props.sv ***
// concurrent checks on the wake-up timer control block ports
`include "wake_defines.vh"
module wake_unit_props #(
  parameter [19:0] CAL_LO_CYCLES = 20,
  parameter [19:0] CAL_HI_CYCLES = 400
) (
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [9:0] reg_addr_in,
  input wire reg_wr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  input wire cs_high_in,
  input wire wake_arm_in,
  input wire crystal_enable_in,
  input wire crystal_osc_in,
  input wire wake_event_out,
  input wire shutdown_out,
  input wire rc_cal_enable_out
);
  timeunit 1ns;
  timeprecision 1ns;
  reg req_reg;
  reg cal_reg;
  wire sd_want = req_reg && cs_high_in;
  wire rd_st = reg_rd_in && reg_addr_in == `WAKE_ADDR_STATUS;
  // anything not readable back returns zero, write-only reload bytes included
  wire rd_zero = reg_rd_in && !(rd_st || reg_addr_in == `WAKE_ADDR_FLAG_CTRL ||
    reg_addr_in == `WAKE_ADDR_SHUTDOWN);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // mirrors of host-written control bits, rebuilt from the bus alone
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_reg <= 1'b0;
      cal_reg <= 1'b0;
    end else if (reg_wr_in && reg_addr_in == `WAKE_ADDR_SHUTDOWN) begin
      req_reg <= reg_wdata_in[0];
    end else if (reg_wr_in && reg_addr_in == `WAKE_ADDR_FLAG_CTRL) begin
      cal_reg <= reg_wdata_in[1];
    end
  end
  a_shutdown_gate: assert property (shutdown_out == $past(sd_want))
    else $error("shutdown output does not follow request and chip select");
  a_cal_enable_copy: assert property ((rc_cal_enable_out != cal_reg) |->
    (cal_reg != $past(cal_reg))) else $error("calibration enable lags its bit");
  a_wake_needs_arm: assert property (wake_event_out |->
    ($past(wake_arm_in) || $past(wake_arm_in, 2))) else $error("wake while disarmed");
  a_wake_one_cycle: assert property (wake_event_out |=> !wake_event_out)
    else $error("wake pulse longer than one cycle");
  a_rdata_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
    else $error("read data moved without a read");
  a_unreadable_zero: assert property ($past(rd_zero) |-> reg_rdata_out == 8'h00)
    else $error("write-only or unmapped read not zero");
  a_status_reserved: assert property ($past(rd_st) |-> !reg_rdata_out[7])
    else $error("reserved status bit set");
  a_crystal_live: assert property ($past(rd_st) |->
    reg_rdata_out[3] == $past(crystal_osc_in)) else $error("crystal level wrong");
  a_crystal_off: assert property ($past(rd_st) && !$past(crystal_enable_in) &&
    !$past(crystal_enable_in, 2) |-> !reg_rdata_out[4]) else $error("settled while off");
endmodule // wake_unit_props

bind wake_unit_top wake_unit_props #(.CAL_LO_CYCLES(CAL_LO_CYCLES),
  .CAL_HI_CYCLES(CAL_HI_CYCLES)) props_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cs_high_in(cs_high_in),
  .wake_arm_in(wake_arm_in), .crystal_enable_in(crystal_enable_in),
  .crystal_osc_in(crystal_osc_in), .wake_event_out(wake_event_out),
  .shutdown_out(shutdown_out), .rc_cal_enable_out(rc_cal_enable_out));

// *** wake_host_model.sv ***
// host model: register bus master and owner of the serial chip select
`include "wake_defines.vh"
module wake_host_model (
  input wire ref_clk_in,
  input wire [7:0] reg_rdata_in,
  output logic [9:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  output logic cs_high_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr_out = 10'h000;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
    cs_high_out = 1'b1;
  end
  // idle bus lines are inverted so a stale address never looks valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  // data is taken one edge after the strobe, where it stands
  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(posedge ref_clk_in);
    #1;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(posedge ref_clk_in);
    #1;
    d = reg_rdata_in;
  endtask
  // upper byte always goes first, lower never alone
  task automatic wr_reload(input logic [7:0] h, input logic [7:0] l);
    wr(`WAKE_ADDR_RELOAD_UPPER, h);
    wr(`WAKE_ADDR_RELOAD_LOWER, l);
  endtask
  task automatic set_cs(input logic c);
    @(posedge ref_clk_in);
    #1;
    cs_high_out = c;
  endtask
endmodule // wake_host_model

// *** wakeup_timer_control_tb_top.sv ***
// self-checking bench for the wake-up timer control block
`include "wake_defines.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module wakeup_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RCP = 8;
  int errors = 0;
  int checks_done = 0;
  int n, p, ph = 0;
  logic ref_clk_in = 1'b0, rst_n_in = 1'b0, arm = 1'b0, clk_sel = 1'b1, x_en = 1'b0;
  logic rc = 1'b0, xo = 1'b0, rc_run = 1'b0, xo_run = 1'b0;
  logic [2:0] presc = 3'h0;
  logic [9:0] addr;
  logic wr, rd, cs, wake, sd, cal_en;
  logic [7:0] wdata, rdata, v;
  always #5 ref_clk_in = ~ref_clk_in;
  // slow oscillators run at RCP reference cycles a period and freeze when stopped
  always @(posedge ref_clk_in) begin
    #1;
    ph++;
    if (ph % (RCP / 2) == 0 && rc_run) rc = ~rc;
    if (ph % (RCP / 2) == 0 && xo_run) xo = ~xo;
  end
  wake_host_model host (.ref_clk_in(ref_clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd), .cs_high_out(cs));
  // short calibration window so a fast rc fits in range
  wake_unit_top #(.CAL_LO_CYCLES(20'h00014), .CAL_HI_CYCLES(20'h00190)) uut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .cs_high_in(cs),
    .wake_arm_in(arm), .timer_clock_select_in(clk_sel), .crystal_enable_in(x_en),
    .presc_sel_in(presc), .rc_osc_in(rc), .crystal_osc_in(xo), .wake_event_out(wake),
    .shutdown_out(sd), .rc_cal_enable_out(cal_en));
  task automatic conclude;
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // cycles to the next wake pulse, bounded so a dead timer cannot hang the run
  task automatic gap(output int c);
    c = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      c++;
    end while (wake !== 1'b1 && c < 6000);
    if (c >= 6000) begin
      errors++;
      conclude();
    end
  endtask
  task automatic pulses(input int cyc, output int q);
    q = 0;
    repeat (cyc) begin
      @(posedge ref_clk_in);
      #1;
      if (wake === 1'b1) q++;
    end
  endtask
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    host.rd(`WAKE_ADDR_STATUS, v);
    `CHK("status", e, v & m)
  endtask
  task automatic poll(input int b, input int lim);
    n = 0;
    do begin
      host.rd(`WAKE_ADDR_STATUS, v);
      n++;
    end while (v[b] !== 1'b1 && n < lim);
    if (v[b] !== 1'b1) begin
      errors++;
      conclude();
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    st(8'hFF, 8'h05);
    for (int i = 0; i < 8; i++) begin
      host.rd({6'h30, i[1:0] == 2'h0 ? 4'hE : 4'hF}, v);
      `CHK("write-only read", 8'h00, v)
    end
    host.rd(10'h3FF, v);
    `CHK("unmapped read", 8'h00, v)
    host.wr(`WAKE_ADDR_STATUS, 8'hFF);
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h01);
    st(8'hFF, 8'h01);
    rc_run = 1'b1;
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h02);
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK("cal enable", 1'b1, cal_en)
    poll(5, 500);
    `CHK("cal good", 8'h20, v & 8'h60)
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h00);
    st(8'h60, 8'h00);
    rc_run = 1'b0;
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h02);
    poll(5, 1500);
    `CHK("cal stopped", 8'h60, v & 8'h60)
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h00);
    x_en = 1'b1;
    xo_run = 1'b1;
    poll(4, 4000);
    `CHK("crystal settled", 1'b1, v[4])
    xo_run = 1'b0;
    xo = 1'b1;
    st(8'h08, 8'h08);
    x_en = 1'b0;
    st(8'h10, 8'h00);
    rc_run = 1'b1;
    arm = 1'b1;
    host.wr_reload(8'h01, 8'h02);
    st(8'h01, 8'h00);
    gap(n);
    gap(n);
    `CHK("gap full", (16'h0102 + 1) * RCP, n)
    host.wr(`WAKE_ADDR_RELOAD_UPPER, 8'h00);
    gap(n);
    gap(n);
    `CHK("gap pending", (16'h0102 + 1) * RCP, n)
    host.wr_reload(8'h00, 8'h05);
    gap(n);
    gap(n);
    `CHK("gap short", 6 * RCP, n)
    presc = 3'h1;
    gap(n);
    gap(n);
    `CHK("gap div4", 6 * 4 * RCP, n)
    st(8'h02, 8'h02);
    arm = 1'b0;
    pulses(400, p);
    `CHK("disarmed", 0, p)
    // crystal parked low so the source switch below makes no false rising edge
    xo = 1'b0;
    st(8'h08, 8'h00);
    arm = 1'b1;
    clk_sel = 1'b0;
    pulses(400, p);
    `CHK("crystal source", 0, p)
    clk_sel = 1'b1;
    pulses(400, p);
    `CHK("rc source", 1'b1, p > 0)
    // freeze the timer and let its pipeline drain, since a timeout beats the clear
    rc_run = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    host.wr(`WAKE_ADDR_FLAG_CTRL, 8'h01);
    st(8'h06, 8'h00);
    host.rd(`WAKE_ADDR_FLAG_CTRL, v);
    `CHK("flag control", 8'h01, v)
    host.set_cs(1'b0);
    host.wr(`WAKE_ADDR_SHUTDOWN, 8'h01);
    repeat (3) @(posedge ref_clk_in);
    #1;
    `CHK("shutdown held", 1'b0, sd)
    host.set_cs(1'b1);
    @(posedge ref_clk_in);
    #1;
    `CHK("shutdown", 1'b1, sd)
    host.rd(`WAKE_ADDR_SHUTDOWN, v);
    `CHK("shutdown bit", 8'h01, v)
    conclude();
  end
endmodule // wakeup_timer_control_tb_top
